// ---- src/ext_irq_cfg_filter_mask.sv ----
// External interrupt trigger, noise filter and mask block with AXI4-Lite registers
//
// Functional notes
// - Trigger code 000 requests on low level, 001 on high level.
// - Codes 01x falling edge, 10x rising edge, 11x both edges; bit 0 ignored.
// - Trigger register: 3-bit field per input 16..23, nibble-spaced, 23 at top.
// - Bit above each trigger field enables that input's noise filter.
// - Filter length programmable only for inputs 16..23, each independent.
// - Clock select 0 uses bus clock; 1 uses strap-chosen external or oscillator clock.
// - Each filtered input has a 7-bit width; top field sits at bits 30..24.
// - Filter registers: byte per input, select bit 7, width 6..0; low register 16..19.
// - High filter register serves inputs 20..23, input 20 in lowest byte.
// - Both filter registers read/write, reset zero; two lower slots reserved.
// - Mask bit per input 4..23 at its own position; 1 blocks the request.
// - Mask bits 3..0 reserved, read as zero.
`timescale 1ns/1ps

module ext_irq_cfg_filter_mask
  import ext_irq_pkg::*;
(
  input  wire logic        aclk,                 // Bus and bus-rate filter clock
  input  wire logic        aresetn,              // Synchronous reset, active low
  // AXI4-Lite write address
  input  wire logic        awvalid,              // Write address valid
  output logic             awready,              // Write address ready
  input  wire logic [31:0] awaddr,               // Write byte address
  // AXI4-Lite write data
  input  wire logic        wvalid,               // Write data valid
  output logic             wready,               // Write data ready
  input  wire logic [31:0] wdata,                // Write data
  input  wire logic [3:0]  wstrb,                // Write byte enables
  // AXI4-Lite write response
  output logic             bvalid,               // Write response valid
  input  wire logic        bready,               // Write response ready
  output logic [1:0]       bresp,                // Write response code
  // AXI4-Lite read address
  input  wire logic        arvalid,              // Read address valid
  output logic             arready,              // Read address ready
  input  wire logic [31:0] araddr,               // Read byte address
  // AXI4-Lite read data
  output logic             rvalid,               // Read data valid
  input  wire logic        rready,               // Read data ready
  output logic [31:0]      rdata,                // Read data
  output logic [1:0]       rresp,                // Read response code
  // Request pins and clocks
  input  wire logic [23:4] ext_irq_in,           // External requests, 4..15 used raw
  input  wire logic        external_clock_input, // Alternate filter clock, sampled
  input  wire logic        oscillator_clock,     // Alternate filter clock, sampled
  input  wire logic        operating_mode_strap, // 0 external, 1 oscillator
  output logic             irq                   // Unmasked request pending
);

  // ==========================================================================
  // Register storage
  logic [31:0] trig_ctrl;
  logic [31:0] flt_lo;
  logic [31:0] flt_hi;
  logic [31:0] ext_irq_mask;
  logic [31:0] status;
  logic        strap_taken;
  logic        strap_q;
  logic        alt_prev;

  // Byte-lane merge of a write
  function automatic logic [31:0] merge(input logic [31:0] old_v,
                                        input logic [31:0] new_v,
                                        input logic [3:0]  strb);
    logic [31:0] res;
    res = old_v;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[8*b +: 8] = new_v[8*b +: 8];
      end
    end
    return res;
  endfunction : merge

  // ==========================================================================
  // Write channel: address and data taken together, response follows
  wire logic wr_fire   = awvalid & wvalid & ~bvalid;
  wire logic wr_trig   = wr_fire & (awaddr == ADDR_TRIG_CTRL_HI);
  wire logic wr_flt_lo = wr_fire & (awaddr == ADDR_FLT_CTRL_LO);
  wire logic wr_flt_hi = wr_fire & (awaddr == ADDR_FLT_CTRL_HI);
  wire logic wr_mask   = wr_fire & (awaddr == ADDR_EXT_IRQ_MASK);
  wire logic wr_stat   = wr_fire & (awaddr == ADDR_IRQ_STATUS);
  wire logic wr_rsvd   = wr_fire & ((awaddr == ADDR_FLT_RSVD_A) |
                                    (awaddr == ADDR_FLT_RSVD_B));
  wire logic wr_hit    = wr_trig | wr_flt_lo | wr_flt_hi | wr_mask | wr_stat | wr_rsvd;

  assign awready = wr_fire;
  assign wready  = wr_fire;

  // Response hold until accepted
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid <= 1'b0;
      bresp  <= RESP_OKAY;
    end else if (wr_fire) begin
      bvalid <= 1'b1;
      bresp  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (bready) begin
      bvalid <= 1'b0;
    end
  end

  // Configuration registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      trig_ctrl    <= RST_TRIG_CTRL_HI;
      flt_lo       <= RST_FLT_CTRL;
      flt_hi       <= RST_FLT_CTRL;
      ext_irq_mask <= RST_EXT_IRQ_MASK;
    end else begin
      if (wr_trig)   trig_ctrl    <= merge(trig_ctrl, wdata, wstrb);
      if (wr_flt_lo) flt_lo       <= merge(flt_lo, wdata, wstrb);
      if (wr_flt_hi) flt_hi       <= merge(flt_hi, wdata, wstrb);
      if (wr_mask)   ext_irq_mask <= merge(ext_irq_mask, wdata, wstrb) & IMPL_BITS;
    end
  end

  // ==========================================================================
  // Read channel: one registered answer
  wire logic rd_fire = arvalid & ~rvalid;
  wire logic rd_trig = araddr == ADDR_TRIG_CTRL_HI;
  wire logic rd_lo   = araddr == ADDR_FLT_CTRL_LO;
  wire logic rd_hi   = araddr == ADDR_FLT_CTRL_HI;
  wire logic rd_mask = araddr == ADDR_EXT_IRQ_MASK;
  wire logic rd_stat = araddr == ADDR_IRQ_STATUS;
  wire logic rd_rsvd = (araddr == ADDR_FLT_RSVD_A) | (araddr == ADDR_FLT_RSVD_B);
  wire logic rd_hit  = rd_trig | rd_lo | rd_hi | rd_mask | rd_stat | rd_rsvd;
  wire logic [31:0] rd_val = ({32{rd_trig}} & trig_ctrl)
                           | ({32{rd_lo}}   & flt_lo)
                           | ({32{rd_hi}}   & flt_hi)
                           | ({32{rd_mask}} & ext_irq_mask)
                           | ({32{rd_stat}} & status);

  assign arready = ~rvalid;

  // Read data hold until accepted
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid <= 1'b0;
      rdata  <= 32'h00000000;
      rresp  <= RESP_OKAY;
    end else if (rd_fire) begin
      rvalid <= 1'b1;
      rdata  <= rd_val;
      rresp  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (rready) begin
      rvalid <= 1'b0;
    end
  end

  // ==========================================================================
  // Alternate filter clock: strap caught after reset release, rising edge tick
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      strap_taken <= 1'b0;
      strap_q     <= 1'b0;
    end else if (!strap_taken) begin
      strap_taken <= 1'b1;
      strap_q     <= operating_mode_strap;
    end
  end

  wire logic alt_clk  = strap_q ? oscillator_clock : external_clock_input;
  wire logic alt_tick = alt_clk & ~alt_prev;

  // Previous alternate clock level
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      alt_prev <= 1'b0;
    end else begin
      alt_prev <= alt_clk;
    end
  end

  // ==========================================================================
  // Filter and trigger detection for inputs 16..23
  wire logic [63:0]        flt_all = {flt_hi, flt_lo};
  logic [NUM_FLT_IN-1:0]   det_hi;

  for (genvar g = 0; g < NUM_FLT_IN; g++) begin : g_in
    in_cfg_t    cfg;
    logic [6:0] cnt;
    logic       flt;
    logic       prev;
    wire logic  pin  = ext_irq_in[FIRST_FLT_IN + g];
    wire logic  tick = cfg.clk_sel ? alt_tick : 1'b1;
    wire logic  eff  = cfg.flt_en ? flt : pin;
    wire logic  done = ({1'b0, cnt} + 8'h01) >= {1'b0, cfg.width};

    assign cfg.flt_en  = trig_ctrl[TRIG_STRIDE*g + 3];
    assign cfg.trig    = trig_ctrl[TRIG_STRIDE*g +: 3];
    assign cfg.clk_sel = flt_all[FLT_STRIDE*g + 7];
    assign cfg.width   = flt_all[FLT_STRIDE*g +: 7];

    // Stability counter; filter output tracks pin while bypassed
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        cnt <= 7'h00;
        flt <= 1'b0;
      end else if (!cfg.flt_en || pin == flt) begin
        cnt <= 7'h00;
        flt <= pin;
      end else if (tick) begin
        if (done) begin
          cnt <= 7'h00;
          flt <= pin;
        end else begin
          cnt <= cnt + 7'h01;
        end
      end
    end

    // Previous filtered level for edges
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        prev <= 1'b0;
      end else begin
        prev <= eff;
      end
    end

    // Trigger decode
    always_comb begin
      case (cfg.trig[2:1])
        2'h0:      det_hi[g] = (cfg.trig == TRIG_LOW_LEVEL) ? ~eff : eff;
        TRIG_FALL: det_hi[g] = prev & ~eff;
        TRIG_RISE: det_hi[g] = ~prev & eff;
        TRIG_BOTH: det_hi[g] = prev ^ eff;
        default:   det_hi[g] = 1'b0;
      endcase
    end
  end

  // ==========================================================================
  // Sticky status, write-one-to-clear, set wins; mask gates output only
  wire logic [31:0] set_vec = {8'h00, det_hi, ext_irq_in[15:4], 4'h0};
  wire logic [31:0] clr_vec = wr_stat ? (wdata & {{8{wstrb[3]}}, {8{wstrb[2]}},
                                                  {8{wstrb[1]}}, {8{wstrb[0]}}})
                                      : 32'h00000000;
  wire logic [31:0] next_status = ((status & ~clr_vec) | set_vec) & IMPL_BITS;

  // Status update
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      status <= RST_IRQ_STATUS;
    end else begin
      status <= next_status;
    end
  end

  assign irq = |(status & ~ext_irq_mask);

endmodule : ext_irq_cfg_filter_mask

// ---- src/ext_irq_pkg.sv ----
// Package with register map, field layout and constants of the external interrupt block
package ext_irq_pkg;

  // ==========================================================================
  // Register byte addresses
  localparam logic [31:0] ADDR_TRIG_CTRL_HI  = 32'h56000090;
  localparam logic [31:0] ADDR_FLT_RSVD_A    = 32'h56000094;
  localparam logic [31:0] ADDR_FLT_RSVD_B    = 32'h56000098;
  localparam logic [31:0] ADDR_FLT_CTRL_LO   = 32'h5600009c;
  localparam logic [31:0] ADDR_FLT_CTRL_HI   = 32'h4c6000a0;
  localparam logic [31:0] ADDR_EXT_IRQ_MASK  = 32'h560000a4;
  localparam logic [31:0] ADDR_IRQ_STATUS    = 32'h560000c0;

  // ==========================================================================
  // Reset values
  localparam logic [31:0] RST_TRIG_CTRL_HI   = 32'h00000000;
  localparam logic [31:0] RST_FLT_CTRL       = 32'h00000000;
  localparam logic [31:0] RST_EXT_IRQ_MASK   = 32'h00fffff0;
  localparam logic [31:0] RST_IRQ_STATUS     = 32'h00000000;

  // ==========================================================================
  // Field layout
  localparam int          NUM_FLT_IN         = 8;      // Filtered inputs 16..23
  localparam int          FIRST_FLT_IN       = 16;
  localparam int          LOW_IN             = 4;      // Lowest maskable input
  localparam int          TOP_IN             = 23;
  localparam int          TRIG_STRIDE        = 4;      // One nibble per input
  localparam int          FLT_STRIDE         = 8;      // One byte per input
  localparam logic [31:0] IMPL_BITS          = 32'h00fffff0;

  // ==========================================================================
  // Trigger codes
  localparam logic [2:0]  TRIG_LOW_LEVEL     = 3'h0;
  localparam logic [2:0]  TRIG_HIGH_LEVEL    = 3'h1;
  localparam logic [1:0]  TRIG_FALL          = 2'h1;   // Pattern 01x
  localparam logic [1:0]  TRIG_RISE          = 2'h2;   // Pattern 10x
  localparam logic [1:0]  TRIG_BOTH          = 2'h3;   // Pattern 11x

  // ==========================================================================
  // Bus responses
  localparam logic [1:0]  RESP_OKAY          = 2'h0;
  localparam logic [1:0]  RESP_SLVERR        = 2'h2;

  // Per-input configuration bundle
  typedef struct packed {
    logic       flt_en;     // Noise filter enable
    logic [2:0] trig;       // Trigger type
    logic       clk_sel;    // 0 bus clock, 1 alternate clock
    logic [6:0] width;      // Filter width in ticks
  } in_cfg_t;

endpackage : ext_irq_pkg

// ---- tb/ext_irq_cfg_filter_mask_tb.sv ----
// Self-checking bench for the external interrupt trigger, filter and mask block
`timescale 1ns/1ps
module ext_irq_cfg_filter_mask_tb;
  import ext_irq_pkg::*;
  // ==========================================================================
  // Signals and instances
  logic        aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0;
  logic        bready = 1'b1, rready = 1'b1, strap = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid, irq, xclk, oclk;
  logic [31:0] awaddr = '0, wdata = '0, araddr = '0, rdata;
  logic [1:0]  bresp, rresp;
  logic [23:4] pins = '0, ext_irq_in;
  int          n_errors = 0, samples_checked = 0;
  ext_irq_pins ext_irq_pins_i (.aclk, .level_req(pins), .ext_irq_in,
    .external_clock_input(xclk), .oscillator_clock(oclk));
  ext_irq_cfg_filter_mask ext_irq_cfg_filter_mask_i (.aclk, .aresetn, .awvalid, .awready,
    .awaddr, .wvalid, .wready, .wdata, .wstrb(4'hf), .bvalid, .bready, .bresp, .arvalid,
    .arready, .araddr, .rvalid, .rready, .rdata, .rresp, .ext_irq_in,
    .external_clock_input(xclk), .oscillator_clock(oclk), .operating_mode_strap(strap), .irq);
  initial forever #4 aclk = ~aclk;
  // Compare and bus tasks
  task automatic chk(input logic [31:0] g, e, input string m);
    samples_checked++;
    if (g !== e) begin
      n_errors++;
      $display("FAIL %0t %s got %h exp %h", $time, m, g, e);
    end
  endtask : chk
  task automatic wr(input logic [31:0] a, d, input logic [1:0] e);
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    awaddr <= a;
    wdata <= d;
    do @(posedge aclk); while (awready !== 1'b1);
    chk({31'h0, wready}, 32'h1, "wready");
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    do @(posedge aclk); while (bvalid !== 1'b1);
    chk({30'h0, bresp}, {30'h0, e}, "bresp");
  endtask : wr
  task automatic rd(input logic [31:0] a, d, input logic [1:0] e);
    arvalid <= 1'b1;
    araddr <= a;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge aclk); while (rvalid !== 1'b1);
    chk(rdata, d, "rdata");
    chk({30'h0, rresp}, {30'h0, e}, "rresp");
  endtask : rd
  task automatic settle(input int n);
    repeat (n) @(posedge aclk);
  endtask : settle
  // Scenarios
  task automatic t_reset;
    rd(ADDR_FLT_CTRL_LO, 32'h0, RESP_OKAY);
    rd(ADDR_FLT_CTRL_HI, 32'h0, RESP_OKAY);
    rd(ADDR_EXT_IRQ_MASK, 32'h00fffff0, RESP_OKAY);
    chk({31'h0, irq}, 32'h0, "irq masked at reset");
  endtask : t_reset
  task automatic t_regs;
    wr(ADDR_TRIG_CTRL_HI, 32'hffffffff, RESP_OKAY);
    rd(ADDR_TRIG_CTRL_HI, 32'hffffffff, RESP_OKAY);
    wr(ADDR_FLT_CTRL_LO, 32'h5a5a5a5a, RESP_OKAY);
    rd(ADDR_FLT_CTRL_LO, 32'h5a5a5a5a, RESP_OKAY);
    wr(ADDR_FLT_CTRL_HI, 32'ha5a5a5a5, RESP_OKAY);
    rd(ADDR_FLT_CTRL_HI, 32'ha5a5a5a5, RESP_OKAY);
    wr(ADDR_FLT_RSVD_A, 32'hffffffff, RESP_OKAY);
    rd(ADDR_FLT_RSVD_A, 32'h0, RESP_OKAY);
    rd(ADDR_FLT_RSVD_B, 32'h0, RESP_OKAY);
    wr(32'h56000000, 32'h1, RESP_SLVERR);
    rd(32'h56000000, 32'h0, RESP_SLVERR);
    wr(ADDR_FLT_CTRL_LO, 32'h0, RESP_OKAY);
    wr(ADDR_FLT_CTRL_HI, 32'h0, RESP_OKAY);
  endtask : t_regs
  task automatic t_trig(input int n);
    logic [2:0]  e [8] = '{3'h3, 3'h7, 3'h2, 3'h2, 3'h1, 3'h1, 3'h3, 3'h3};
    logic [31:0] b, t;
    b = 32'h1 << n;
    wr(ADDR_EXT_IRQ_MASK, 32'h0, RESP_OKAY);
    for (int c = 0; c < 8; c++) begin
      t = 32'h11111111 & ~(32'hf << 4 * (n - 16)) | (32'(c) << 4 * (n - 16));
      pins[n] <= 1'b1;
      wr(ADDR_TRIG_CTRL_HI, t, RESP_OKAY);
      settle(4);
      wr(ADDR_IRQ_STATUS, IMPL_BITS, RESP_OKAY);
      rd(ADDR_IRQ_STATUS, e[c][2] ? b : 32'h0, RESP_OKAY);
      pins[n] <= 1'b0;
      settle(4);
      rd(ADDR_IRQ_STATUS, e[c][1] ? b : 32'h0, RESP_OKAY);
      wr(ADDR_IRQ_STATUS, IMPL_BITS, RESP_OKAY);
      pins[n] <= 1'b1;
      settle(4);
      rd(ADDR_IRQ_STATUS, e[c][0] ? b : 32'h0, RESP_OKAY);
      chk({31'h0, irq}, {31'h0, e[c][0]}, "irq");
    end
    pins[n] <= 1'b0;
  endtask : t_trig
  task automatic t_filter(input logic [31:0] f, input int s, l);
    wr(ADDR_TRIG_CTRL_HI, 32'h111111c1, RESP_OKAY);
    wr(ADDR_FLT_CTRL_LO, f, RESP_OKAY);
    settle(40);
    wr(ADDR_IRQ_STATUS, IMPL_BITS, RESP_OKAY);
    pins[17] <= 1'b1;
    settle(s);
    pins[17] <= 1'b0;
    settle(40);
    rd(ADDR_IRQ_STATUS, 32'h0, RESP_OKAY);
    pins[17] <= 1'b1;
    settle(l);
    pins[17] <= 1'b0;
    settle(40);
    rd(ADDR_IRQ_STATUS, 32'h00020000, RESP_OKAY);
  endtask : t_filter
  // Mid-run reset with strap high: alternate filter clock becomes the fast one
  task automatic t_osc;
    aresetn <= 1'b0;
    strap <= 1'b1;
    settle(4);
    aresetn <= 1'b1;
    settle(1);
    t_filter(32'h00008200, 1, 12);
  endtask : t_osc
  task automatic t_mask;
    wr(ADDR_IRQ_STATUS, IMPL_BITS, RESP_OKAY);
    wr(ADDR_EXT_IRQ_MASK, 32'hffffffff, RESP_OKAY);
    rd(ADDR_EXT_IRQ_MASK, 32'h00fffff0, RESP_OKAY);
    pins[4] <= 1'b1;
    settle(4);
    rd(ADDR_IRQ_STATUS, 32'h10, RESP_OKAY);
    chk({31'h0, irq}, 32'h0, "irq masked");
    wr(ADDR_EXT_IRQ_MASK, 32'hffffffef, RESP_OKAY);
    chk({31'h0, irq}, 32'h1, "irq unmasked");
    pins[4] <= 1'b0;
    settle(2);
    wr(ADDR_IRQ_STATUS, IMPL_BITS, RESP_OKAY);
    chk({31'h0, irq}, 32'h0, "irq cleared");
  endtask : t_mask
  // Verdict
  task automatic test_done;
    $display("errors %0d checks %0d", n_errors, samples_checked);
    if (n_errors == 0 && samples_checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : test_done
  initial begin
    #100us;
    n_errors++;
    test_done;
  end
  initial begin
    settle(4);
    aresetn <= 1'b1;
    settle(1);
    t_reset;
    $display("reset test done");
    t_regs;
    $display("register test done");
    t_trig(16);
    t_trig(23);
    $display("trigger test done");
    t_filter(32'h00000500, 3, 8);
    t_filter(32'h00008200, 4, 80);
    $display("filter test done");
    t_osc;
    $display("strap test done");
    t_mask;
    $display("mask test done");
    test_done;
  end
endmodule : ext_irq_cfg_filter_mask_tb
bind ext_irq_cfg_filter_mask ext_irq_props ext_irq_props_i (.aclk, .aresetn, .awvalid,
  .awready, .wvalid, .bvalid, .bready, .arvalid, .araddr, .rvalid, .rready, .rdata, .rresp);

// ---- tb/ext_irq_pins.sv ----
// Model of the devices driving the request pins and alternate clocks
`timescale 1ns/1ps
module ext_irq_pins (
  input  wire logic        aclk,                 // Bench clock
  input  wire logic [23:4] level_req,            // Levels to present
  output logic      [23:4] ext_irq_in,           // Request pins
  output logic             external_clock_input, // Slow clock, 16 cycles
  output logic             oscillator_clock      // Fast clock, 2 cycles
);
  // ==========================================================================
  // Pins follow requests one cycle late; clocks divided from aclk
  logic [2:0] div = 3'h0;
  initial ext_irq_in = '0;
  initial external_clock_input = 1'b0;
  initial oscillator_clock = 1'b0;
  always @(posedge aclk) begin
    ext_irq_in <= level_req;
    div <= div + 3'h1;
    oscillator_clock <= ~oscillator_clock;
    if (div == 3'h7) external_clock_input <= ~external_clock_input;
  end
endmodule : ext_irq_pins

// ---- tb/ext_irq_props.sv ----
// Checker of bus handshakes and register read values
`timescale 1ns/1ps
module ext_irq_props
  import ext_irq_pkg::*;
(
  input wire logic        aclk,    // Clock
  input wire logic        aresetn, // Reset, active low
  input wire logic        awvalid, // Write address valid
  input wire logic        awready, // Write address ready
  input wire logic        wvalid,  // Write data valid
  input wire logic        bvalid,  // Write response valid
  input wire logic        bready,  // Write response ready
  input wire logic        arvalid, // Read address valid
  input wire logic [31:0] araddr,  // Read address
  input wire logic        rvalid,  // Read data valid
  input wire logic        rready,  // Read data ready
  input wire logic [31:0] rdata,   // Read data
  input wire logic [1:0]  rresp    // Read response
);
  // ==========================================================================
  // Assertions
  default clocking @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  logic ar_take;
  // Read request taken at this edge
  assign ar_take = arvalid && !rvalid;
  chk_write_answer: assert property (awvalid && wvalid && !bvalid |=> bvalid)
    else $error("write not answered");
  chk_write_ready: assert property (awready |-> awvalid && wvalid && !bvalid)
    else $error("write taken out of turn");
  chk_write_drop: assert property (bvalid && bready |=> !bvalid)
    else $error("write answer repeated");
  chk_read_answer: assert property (ar_take |=> rvalid)
    else $error("read not answered");
  chk_read_drop: assert property (rvalid && rready |=> !rvalid)
    else $error("read answer repeated");
  chk_mask_low: assert property (ar_take && araddr == ADDR_EXT_IRQ_MASK |=> rdata[3:0] == 4'h0)
    else $error("mask low bits not zero");
  chk_rsvd_zero: assert property (ar_take && araddr == ADDR_FLT_RSVD_B |=> rdata == 32'h0)
    else $error("reserved slot not zero");
  chk_bad_addr: assert property (ar_take && araddr == 32'h56000000 |=> rresp == RESP_SLVERR)
    else $error("unmapped read not refused");
endmodule : ext_irq_props
